// ---- rbd_pkg.sv ----
// Package of constants, register map and enumerations for the reset and access block
package rbd_pkg;
  // Register indices (word offsets); byte address is four times the index
  localparam logic [3:0] RBD_REG_CTRL = 4'h0;
  localparam logic [3:0] RBD_REG_STATUS = 4'h1;
  localparam logic [3:0] RBD_REG_PROT = 4'h2;
  localparam logic [3:0] RBD_REG_CAUSE = 4'h3;
  // Control field positions
  localparam int RBD_CTRL_BOD_IRQ_LVL = 0;
  localparam int RBD_CTRL_BOD_RST_EN = 1;
  localparam int RBD_CTRL_BOD_RST_LVL = 2;
  localparam int RBD_CTRL_ISP_PIN_DIS = 3;
  localparam int RBD_CTRL_RST_PIN_SEL = 4;
  localparam logic [7:0] RBD_CTRL_RESET = 8'h10;
  // Cause flag positions
  localparam int RBD_CAUSE_POR = 0;
  localparam int RBD_CAUSE_PIN = 1;
  localparam int RBD_CAUSE_WDT = 2;
  localparam int RBD_CAUSE_BOD = 3;
  localparam logic [3:0] RBD_CAUSE_RESET = 4'h1;
  // Reset vector fetched on release
  localparam logic [31:0] RBD_RESET_VECTOR = 32'h0000_0000;
  // Minimum reset pulse and its count at 100 MHz, rounded up
  localparam int RBD_CLK_MHZ = 100;
  localparam int RBD_MIN_PULSE_NS = 50;
  localparam int RBD_MIN_PULSE_CYC = (RBD_MIN_PULSE_NS * RBD_CLK_MHZ + 999) / 1000;
  // Reset stretch after all sources release
  localparam int RBD_STRETCH_CYC = 4;
  // Debug resources
  localparam int RBD_NUM_BREAKPOINTS = 4;
  localparam int RBD_NUM_WATCHPOINTS = 2;
  // Protection levels
  typedef enum logic [1:0] {
    RBD_PROT_NONE, RBD_PROT_ONE, RBD_PROT_TWO, RBD_PROT_THREE
  } rbd_prot_t;
  typedef enum logic [1:0] {
    RBD_ST_RESET, RBD_ST_STRETCH, RBD_ST_RUN
  } rbd_state_t;
endpackage

// ---- rbd_sync_if.sv ----
// Interface carrying synchronised pin levels from the input synchroniser
`timescale 1ns/1ps
interface rbd_sync_if;
  logic rst_pin_n;
  logic bod_irq;
  logic bod_rst;
  modport src (output rst_pin_n, output bod_irq, output bod_rst);
  modport dst (input rst_pin_n, input bod_irq, input bod_rst);
endinterface

// ---- rbd_sync.sv ----
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module rbd_sync (
  input wire logic core_clk,
  input wire logic rst_pin_n_raw,
  input wire logic bod_irq_raw,
  input wire logic bod_rst_raw,
  rbd_sync_if.src sync
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } rbd_sync_state_t;
  rbd_sync_state_t st_reg;
  rbd_sync_state_t st_next;
  // First stage feeds only the second; no reset so a held pin is seen at once
  always_comb begin
    st_next = st_reg;
    st_next.s1 = {rst_pin_n_raw, bod_irq_raw, bod_rst_raw};
    st_next.s2 = st_reg.s1;
  end
  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end
  assign sync.rst_pin_n = st_reg.s2[2];
  assign sync.bod_irq = st_reg.s2[1];
  assign sync.bod_rst = st_reg.s2[0];
endmodule

// ---- rbd_top.sv ----
// Chip reset merge, brownout handling, test port select and protection gating
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module rbd_top #(
  parameter logic [31:0] PROT_PATTERN_ONE = 32'h1234_5678,
  parameter logic [31:0] PROT_PATTERN_TWO = 32'h8765_4321,
  parameter logic [31:0] PROT_PATTERN_THREE = 32'h4321_8765,
  parameter int NUM_BREAKPOINTS = rbd_pkg::RBD_NUM_BREAKPOINTS,
  parameter int NUM_WATCHPOINTS = rbd_pkg::RBD_NUM_WATCHPOINTS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic por_n,
  input wire logic reset_pin_n,
  input wire logic wdt_reset,
  input wire logic bod_below_irq_lvl,
  input wire logic bod_below_rst_lvl,
  input wire logic deep_pd,
  input wire logic low_power_mode,
  input wire logic [31:0] prot_word,
  input wire logic boot_select_pin,
  input wire logic bod_irq_enable,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic chip_reset,
  output logic reset_status_output,
  output logic osc_start,
  output logic osc_select_irc,
  output logic flash_init,
  output logic [31:0] fetch_addr,
  output logic wake_req,
  output logic bod_irq_req,
  output logic bod_irq_cpu,
  output logic scan_mode,
  output logic swd_enable,
  output logic isp_allowed,
  output logic isp_partial_only,
  output logic isp_full_erase_only,
  output logic iap_allowed,
  output logic [2:0] num_breakpoints,
  output logic [1:0] num_watchpoints
);
  rbd_sync_if sync ();
  logic bod_rst_sel;
  logic raw_src;
  logic pin_n_gated;

  // Pin and analog levels enter the clock domain through two flops
  rbd_sync u_sync (
    .core_clk(core_clk),
    .rst_pin_n_raw(reset_pin_n),
    .bod_irq_raw(bod_below_irq_lvl),
    .bod_rst_raw(bod_below_rst_lvl),
    .sync(sync.src)
  );

  typedef struct packed {
    rbd_pkg::rbd_state_t state;
    logic [2:0] cnt;
    logic [7:0] ctrl;
    logic [3:0] cause;
    rbd_pkg::rbd_prot_t prot;
    logic isp_pin_dis;
    logic [1:0] rel;
    logic rd_pend;
    logic [31:0] rdata;
  } rbd_state_s_t;
  rbd_state_s_t st_reg;
  rbd_state_s_t st_next;

  // Protection level decoding feeds the reset capture; gating uses the latched level
  function automatic rbd_pkg::rbd_prot_t decode_prot(input logic [31:0] w);
    if (w == PROT_PATTERN_THREE) begin
      decode_prot = rbd_pkg::RBD_PROT_THREE;
    end else if (w == PROT_PATTERN_TWO) begin
      decode_prot = rbd_pkg::RBD_PROT_TWO;
    end else if (w == PROT_PATTERN_ONE) begin
      decode_prot = rbd_pkg::RBD_PROT_ONE;
    end else begin
      decode_prot = rbd_pkg::RBD_PROT_NONE;
    end
  endfunction

  // Brownout reset threshold choice on synchronised levels; the interrupt uses the same synchronised levels
  assign bod_rst_sel = st_reg.ctrl[rbd_pkg::RBD_CTRL_BOD_RST_EN] &
    (st_reg.ctrl[rbd_pkg::RBD_CTRL_BOD_RST_LVL] ? sync.bod_irq : sync.bod_rst);
  // Pin counts only when selected as reset and not in deep power-down
  assign pin_n_gated = sync.rst_pin_n | deep_pd |
    ~st_reg.ctrl[rbd_pkg::RBD_CTRL_RST_PIN_SEL];
  // Any source forces reset at once; release waits for the stretch
  assign raw_src = ~por_n | ~pin_n_gated | wdt_reset | bod_rst_sel | srst;

  always_comb begin
    st_next = st_reg;
    st_next.rd_pend = reg_rd;
    // Release synchroniser shifts ones in once all sources are quiet
    st_next.rel = raw_src ? 2'h0 : {st_reg.rel[0], 1'b1};
    case (st_reg.state)
      rbd_pkg::RBD_ST_RESET: begin
        st_next.cnt = 3'h0;
        if (st_reg.rel[1]) begin
          st_next.state = rbd_pkg::RBD_ST_STRETCH;
        end
      end
      rbd_pkg::RBD_ST_STRETCH: begin
        st_next.cnt = st_reg.cnt + 3'h1;
        if (st_reg.cnt == 3'(rbd_pkg::RBD_STRETCH_CYC - 1)) begin
          st_next.state = rbd_pkg::RBD_ST_RUN;
        end
      end
      rbd_pkg::RBD_ST_RUN: begin
        st_next.cnt = 3'h0;
      end
      default: begin
        st_next.state = rbd_pkg::RBD_ST_RESET;
      end
    endcase
    if (raw_src) begin
      st_next.state = rbd_pkg::RBD_ST_RESET;
    end
    // Protection level latched while in reset; the pin option follows the control bit
    if (st_reg.state != rbd_pkg::RBD_ST_RUN) begin
      st_next.prot = decode_prot(prot_word);
    end
    // Cause flags: sources set, software write-one clears; set wins
    if (reg_wr && reg_addr == rbd_pkg::RBD_REG_CAUSE) begin
      st_next.cause = st_reg.cause & ~reg_wdata[3:0];
    end
    if (~por_n) begin
      st_next.cause[rbd_pkg::RBD_CAUSE_POR] = 1'b1;
    end
    if (~pin_n_gated) begin
      st_next.cause[rbd_pkg::RBD_CAUSE_PIN] = 1'b1;
    end
    if (wdt_reset) begin
      st_next.cause[rbd_pkg::RBD_CAUSE_WDT] = 1'b1;
    end
    if (bod_rst_sel) begin
      st_next.cause[rbd_pkg::RBD_CAUSE_BOD] = 1'b1;
    end
    // Control writes only land while running; reset restores defaults
    if (st_reg.state != rbd_pkg::RBD_ST_RUN) begin
      st_next.ctrl = rbd_pkg::RBD_CTRL_RESET;
    end else if (reg_wr && reg_addr == rbd_pkg::RBD_REG_CTRL) begin
      st_next.ctrl = reg_wdata[7:0];
    end
    st_next.isp_pin_dis = st_next.ctrl[rbd_pkg::RBD_CTRL_ISP_PIN_DIS];
    // Read data appear in the cycle after the strobe only
    st_next.rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        rbd_pkg::RBD_REG_CTRL: st_next.rdata = {24'h0, st_reg.ctrl};
        rbd_pkg::RBD_REG_STATUS: st_next.rdata = {28'h0, st_reg.state == rbd_pkg::RBD_ST_RUN,
          bod_rst_sel, chip_reset, sync.bod_irq};
        rbd_pkg::RBD_REG_PROT: st_next.rdata = {30'h0, st_reg.prot};
        rbd_pkg::RBD_REG_CAUSE: st_next.rdata = {28'h0, st_reg.cause};
        default: st_next.rdata = 32'h0;
      endcase
    end
  end

  // Every field takes its reset value; cause flags restart with only the power-on flag set
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg.state <= rbd_pkg::RBD_ST_RESET;
      st_reg.cnt <= 3'h0;
      st_reg.ctrl <= rbd_pkg::RBD_CTRL_RESET;
      st_reg.cause <= rbd_pkg::RBD_CAUSE_RESET;
      st_reg.prot <= rbd_pkg::RBD_PROT_NONE;
      st_reg.isp_pin_dis <= 1'b0;
      st_reg.rel <= 2'h0;
      st_reg.rd_pend <= 1'b0;
      st_reg.rdata <= 32'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Reset is combinational on entry so any source bites at once
  assign chip_reset = raw_src | (st_reg.state != rbd_pkg::RBD_ST_RUN);
  assign reset_status_output = ~chip_reset;
  assign osc_start = chip_reset;
  assign flash_init = chip_reset;
  assign osc_select_irc = chip_reset | deep_pd;
  assign fetch_addr = rbd_pkg::RBD_RESET_VECTOR;
  // Wake on a qualified pin low; the stretch lasts 4 cycles, 40 ns at 100 MHz
  assign wake_req = low_power_mode & ~pin_n_gated;
  assign bod_irq_req = st_reg.ctrl[rbd_pkg::RBD_CTRL_BOD_IRQ_LVL] ?
    sync.bod_rst : sync.bod_irq;
  assign bod_irq_cpu = bod_irq_req & bod_irq_enable;
  // Pin level picks the test port; scan never reaches debug
  assign scan_mode = ~sync.rst_pin_n;
  assign swd_enable = sync.rst_pin_n & ~chip_reset &
    (st_reg.prot == rbd_pkg::RBD_PROT_NONE);
  assign isp_allowed = (st_reg.prot != rbd_pkg::RBD_PROT_THREE) &
    ~st_reg.isp_pin_dis & boot_select_pin;
  assign isp_partial_only = st_reg.prot == rbd_pkg::RBD_PROT_ONE;
  assign isp_full_erase_only = st_reg.prot == rbd_pkg::RBD_PROT_TWO;
  assign iap_allowed = 1'b1;
  assign num_breakpoints = 3'(NUM_BREAKPOINTS);
  assign num_watchpoints = 2'(NUM_WATCHPOINTS);
  assign reg_rdata = st_reg.rd_pend ? st_reg.rdata : 32'h0;

  // Checks of the merged reset and access gating
  reset_merge_a: assert property (@(posedge core_clk) (wdt_reset | ~por_n) |-> chip_reset)
    else $error("source did not force reset");
  release_delay_a: assert property (@(posedge core_clk) disable iff (srst)
    $fell(raw_src) |-> chip_reset [*3])
    else $error("reset released too early");
  status_pin_a: assert property (@(posedge core_clk) reset_status_output == ~chip_reset)
    else $error("status output wrong");
  swd_in_reset_a: assert property (@(posedge core_clk) chip_reset |-> !swd_enable)
    else $error("debug on in reset");
  level_three_a: assert property (@(posedge core_clk)
    st_reg.prot == rbd_pkg::RBD_PROT_THREE |-> !isp_allowed && !swd_enable)
    else $error("level three leak");
  deep_pd_pin_a: assert property (@(posedge core_clk) disable iff (srst)
    deep_pd && !wdt_reset && por_n && !bod_rst_sel && $past(st_reg.state)
    == rbd_pkg::RBD_ST_RUN && st_reg.state == rbd_pkg::RBD_ST_RUN |-> !chip_reset)
    else $error("pin acted in deep power-down");
  bod_irq_gate_a: assert property (@(posedge core_clk) bod_irq_cpu |-> bod_irq_enable)
    else $error("interrupt not gated");
  scan_sel_a: assert property (@(posedge core_clk) scan_mode |-> !swd_enable)
    else $error("scan and debug together");
  irc_after_reset_a: assert property (@(posedge core_clk) chip_reset |-> osc_select_irc)
    else $error("oscillator not selected");
  cover_release_c: cover property (@(posedge core_clk) $fell(chip_reset));
  cover_bod_irq_c: cover property (@(posedge core_clk) bod_irq_cpu);
  cover_swd_c: cover property (@(posedge core_clk) swd_enable);
endmodule

// ---- rbd_board.sv ----
// Board reset source model driving the reset pin
`timescale 1ns/1ps
module rbd_board (
  input wire logic core_clk,
  input wire logic pulse_go,
  input wire logic [3:0] pulse_len,
  output logic reset_pin_n
);
  logic [3:0] cnt_reg = 4'h0;
  // Low time counted in core cycles; a pulse of five covers the shortest legal one
  always @(posedge core_clk) begin
    if (pulse_go) cnt_reg <= pulse_len;
    else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
  end
  // Released pin is driven high by the model, never floats
  assign reset_pin_n = (cnt_reg == 4'h0);
endmodule

// ---- reset_brownout_debug_access_bench.sv ----
// Self-checking bench for the reset merge and access gating block
`timescale 1ns/1ps
module reset_brownout_debug_access_bench;
  logic core_clk, srst, por_n, pin_n, wdt_reset, irq_lvl, rst_lvl, deep_pd, lpm, bod_en;
  logic reg_wr, reg_rd, rd_seen, go, chip_reset, rso, osc_start, internal_rc_oscillator, flash_init, wake_req;
  logic boot_sel;
  logic irq_req, irq_cpu, scan_mode, swd_enable, isp_ok, isp_part, isp_full, iap_ok;
  logic [3:0] reg_addr, plen;
  logic [31:0] reg_wdata, reg_rdata, prot_word, fetch_addr;
  logic [2:0] nbp;
  logic [1:0] nwp;
  logic [7:0] lfsr;
  logic [31:0] exp_q[$];
  logic [31:0] words[4];
  int failures, checked;
  rbd_board board (.core_clk(core_clk), .pulse_go(go), .pulse_len(plen), .reset_pin_n(pin_n));
  // Arbitrary protection patterns
  rbd_top #(.PROT_PATTERN_ONE(32'h13579bdf), .PROT_PATTERN_TWO(32'h2468ace0),
    .PROT_PATTERN_THREE(32'h0f1e2d3c)) uut (.core_clk(core_clk), .srst(srst), .por_n(por_n),
    .reset_pin_n(pin_n), .wdt_reset(wdt_reset), .bod_below_irq_lvl(irq_lvl),
    .bod_below_rst_lvl(rst_lvl), .deep_pd(deep_pd), .low_power_mode(lpm),
    .prot_word(prot_word), .boot_select_pin(boot_sel), .bod_irq_enable(bod_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .chip_reset(chip_reset), .reset_status_output(rso),
    .osc_start(osc_start), .osc_select_irc(internal_rc_oscillator), .flash_init(flash_init),
    .fetch_addr(fetch_addr), .wake_req(wake_req), .bod_irq_req(irq_req),
    .bod_irq_cpu(irq_cpu), .scan_mode(scan_mode), .swd_enable(swd_enable),
    .isp_allowed(isp_ok), .isp_partial_only(isp_part), .isp_full_erase_only(isp_full),
    .iap_allowed(iap_ok), .num_breakpoints(nbp), .num_watchpoints(nwp));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Strobe drops one edge later, so the next access always starts a cycle on
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(exp);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] n);
    @(posedge core_clk);
    plen <= n;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
  endtask
  task automatic wait_run();
    int i;
    for (i = 0; i < 60 && chip_reset !== 1'b0; i++) step(1);
    if (i == 60) begin
      failures++;
      report_and_stop();
    end
  endtask
  // Read data are looked at only in the cycle after the strobe
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_seen) check("reg_rdata", reg_rdata, exp_q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end
  initial begin
    {por_n, srst} = 2'b11;
    {wdt_reset, irq_lvl, rst_lvl, deep_pd, lpm, bod_en, reg_wr, reg_rd, go} = 9'h0;
    {reg_addr, plen, reg_wdata, prot_word, rd_seen} = '0;
    lfsr = 8'h29;
    boot_sel = 1'b1;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    wait_run();
    rd(rbd_pkg::RBD_REG_CTRL, 32'h10);
    rd(rbd_pkg::RBD_REG_CAUSE, 32'h1);
    rd(4'h7, 32'h0);
    step(1);
    check("fetch_addr", fetch_addr, 32'h0);
    check("bp_wp", {nbp, nwp}, {27'h0, 3'h4, 2'h2});
    check("irc", internal_rc_oscillator, 1'b0);
    check("rso", rso, 1'b1);
    check("swd", swd_enable, 1'b1);
    // Each source in turn: pin, watchdog, brownout, power-on
    for (int s = 0; s < 4; s++) begin
      wr(rbd_pkg::RBD_REG_CAUSE, 32'hf);
      if (s == 2) wr(rbd_pkg::RBD_REG_CTRL, 32'h12);
      lfsr = lfsr_next(lfsr);
      if (s == 0) pulse(4'h5 + {2'h0, lfsr[1:0]});
      else begin
        @(posedge core_clk);
        wdt_reset <= (s == 1);
        rst_lvl <= (s == 2);
        por_n <= (s != 3);
        @(posedge core_clk);
      end
      step(3);
      check("chip_reset", chip_reset, 1'b1);
      check("osc_flash", {osc_start, flash_init, internal_rc_oscillator}, 3'h7);
      check("rso", rso, 1'b0);
      check("swd", swd_enable, 1'b0);
      if (s == 0) check("scan", scan_mode, 1'b1);
      @(posedge core_clk);
      {wdt_reset, rst_lvl, por_n} <= 3'h1;
      for (int i = 0; i < 12 && pin_n !== 1'b1; i++) @(posedge core_clk);
      step(4);
      check("stretch", chip_reset, 1'b1);
      wait_run();
      rd(rbd_pkg::RBD_REG_CAUSE, 32'h1 << ((s + 1) % 4));
    end
    // Pin ignored in deep power-down, then with its reset function deselected
    for (int k = 0; k < 2; k++) begin
      if (k == 0) deep_pd <= 1'b1;
      else wr(rbd_pkg::RBD_REG_CTRL, 32'h0);
      pulse(4'h6);
      step(5);
      check("pin_ignored", chip_reset, 1'b0);
      if (k == 0) check("irc_dpd", internal_rc_oscillator, 1'b1);
      step(6);
      @(posedge core_clk);
      deep_pd <= 1'b0;
    end
    wr(rbd_pkg::RBD_REG_CTRL, 32'h10);
    lpm <= 1'b1;
    pulse(4'h5);
    step(3);
    check("wake", {wake_req, chip_reset}, 2'h3);
    @(posedge core_clk);
    lpm <= 1'b0;
    wait_run();
    // Brownout interrupt for both level selects and enable states
    for (int k = 0; k < 4; k++) begin
      wr(rbd_pkg::RBD_REG_CTRL, 32'h10 | k[1]);
      bod_en <= k[0];
      irq_lvl <= !k[1];
      rst_lvl <= k[1];
      step(4);
      check("irq_req", irq_req, 1'b1);
      check("irq_cpu", irq_cpu, k[0]);
      check("no_bod_rst", chip_reset, 1'b0);
      if (k == 0) rd(rbd_pkg::RBD_REG_STATUS, 32'h9);
      {irq_lvl, rst_lvl} <= 2'h0;
      step(4);
      check("irq_clear", irq_req, 1'b0);
    end
    // Protection levels, decoded while reset is held
    words = '{{4{lfsr}}, 32'h13579bdf, 32'h2468ace0, 32'h0f1e2d3c};
    for (int l = 3; l >= 0; l--) begin
      @(posedge core_clk);
      prot_word <= words[l];
      wdt_reset <= 1'b1;
      @(posedge core_clk);
      wdt_reset <= 1'b0;
      wait_run();
      rd(rbd_pkg::RBD_REG_PROT, l);
      step(1);
      check("swd_prot", swd_enable, l == 0);
      check("isp", isp_ok, l != 3);
      check("isp_mode", {isp_part, isp_full}, {l == 1, l == 2});
      check("iap", iap_ok, 1'b1);
    end
    wr(rbd_pkg::RBD_REG_CTRL, 32'h18);
    step(2);
    check("isp_pin_off", {isp_ok, swd_enable}, 2'h1);
    wr(rbd_pkg::RBD_REG_CTRL, 32'h10);
    boot_sel <= 1'b0;
    step(2);
    check("isp_no_boot", isp_ok, 1'b0);
    @(posedge core_clk);
    boot_sel <= 1'b1;
    step(2);
    check("isp_boot", isp_ok, 1'b1);
    report_and_stop();
  end
endmodule
